// [pkg/dc_brake_regs.vh]
// Constants for the DC injection brake sequencer.
`ifndef DC_BRAKE_REGS_VH
`define DC_BRAKE_REGS_VH
// Mode selector codes.
`define MODE_OFF 2'h0
`define MODE_STOP 2'h1
`define MODE_FREQ 2'h2
// Trigger method codes.
`define TRIG_EDGE 1'h0
`define TRIG_LEVEL 1'h1
// Tick period in ms and clock rate in kHz; one tick is 0.1 s.
`define TICK_MS 100
`define CLK_KHZ 250000
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define TICK_W 25
// Time fields count 0.1 s steps.
`define TIME_W 10
`define WAIT_MIN_TERM 10'h001
`define WAIT_MAX 10'h032
`define DUR_MAX 10'h258
// Levels in percent, frequency in 0.01 Hz, carrier in 0.1 kHz.
`define LEVEL_W 7
`define LEVEL_MAX 7'h64
`define FREQ_W 16
`define FREQ_MAX 16'h1770
`define CARR_W 8
`define CARR_MIN 8'h14
`define CARR_MAX 8'h96
// Reset defaults.
`define DEF_MODE 2'h1
`define DEF_THRESH 16'h0032
`define DEF_WAIT 10'h000
`define DEF_LEVEL 7'h32
`define DEF_DUR 10'h005
`define DEF_TRIG 1'h1
`define DEF_START_LEVEL 7'h00
`define DEF_START_DUR 10'h000
`define DEF_CARR 8'h32
`endif

// [verilog/dc_injection_brake_control.v]
// DC injection brake sequencer for a motor drive.
`timescale 1ns/1ps
`include "dc_brake_regs.vh"

// Function
// - Mode selector: 00 off, 01 brake on stop, 02 frequency detection; default 01.
// - Stop mode: after run drops and frequency falls below threshold, inject DC.
// - Threshold frequency from start frequency to 60.00 Hz, default 0.50 Hz.
// - Stop braking level 0 to 100 percent, default 50.
// - Stop braking duration 0.0 to 60.0 s, default 0.5, then injection ends.
// - Frequency mode brakes during forward run when output frequency reaches threshold.
// - Frequency mode ignores external brake terminal and stop braking.
// - Frequency mode: brake while reference below threshold, stop when reference and output both reach it.
// - Frequency mode: reference drop after forward run released does not brake.
// - Frequency mode: slowly rising reference brakes at start while below threshold.
// - Start braking level 0 to 100 percent, default 0.
// - Start braking duration 0.0 to 60.0 s, default 0.0 disables it.
// - Braking carrier 2.0 to 15.0 kHz, default 5.0.
// - Trigger method: 00 edge, 01 level; default level.
// - Level trigger: external brake terminal on applies braking, off applies none.
// - Terminal run: releasing external brake ramps frequency back up.
// - Keypad run: releasing external brake leaves output off.
// - Keypad run: external brake coasts for the delay, then brakes.
// - Terminal braking delay 0.1 to 5.0 s, level 0 to 100 percent.
module dc_injection_brake_control #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Settings
  input wire [1:0] brake_mode_select,
  input wire [`FREQ_W-1:0] brake_threshold_freq,
  input wire [`FREQ_W-1:0] start_freq,
  input wire [`TIME_W-1:0] brake_wait_time,
  input wire [`LEVEL_W-1:0] brake_level,
  input wire [`TIME_W-1:0] brake_duration,
  input wire brake_trigger_method,
  input wire [`LEVEL_W-1:0] start_brake_level,
  input wire [`TIME_W-1:0] start_brake_duration,
  input wire [`CARR_W-1:0] brake_carrier_freq,
  // Run and brake inputs
  input wire forward_run_input,
  input wire reverse_run_input,
  input wire keypad_run,
  input wire ext_brake_input,
  input wire [`FREQ_W-1:0] freq_reference,
  input wire [`FREQ_W-1:0] output_freq,
  // Power stage requests
  output reg brake_active,
  output reg coast,
  output reg resume_ramp,
  output reg keypad_stop,
  output reg [`LEVEL_W-1:0] brake_force,
  output reg [`CARR_W-1:0] carrier_freq
);

  // ************************************************************
  // Setting clamps
  // ************************************************************
  // mode decode
  wire mode_stop = (brake_mode_select == `MODE_STOP);
  wire mode_freq = (brake_mode_select == `MODE_FREQ);
  wire [`FREQ_W-1:0] thr_hi = (brake_threshold_freq > `FREQ_MAX) ? `FREQ_MAX : brake_threshold_freq;
  wire [`FREQ_W-1:0] thresh = (thr_hi < start_freq) ? start_freq : thr_hi;
  wire [`TIME_W-1:0] wait_c = (brake_wait_time > `WAIT_MAX) ? `WAIT_MAX : brake_wait_time;
  wire [`TIME_W-1:0] wait_t = (wait_c < `WAIT_MIN_TERM) ? `WAIT_MIN_TERM : wait_c;
  wire [`LEVEL_W-1:0] lvl_c = (brake_level > `LEVEL_MAX) ? `LEVEL_MAX : brake_level;
  wire [`LEVEL_W-1:0] slvl_c = (start_brake_level > `LEVEL_MAX) ? `LEVEL_MAX : start_brake_level;
  wire [`TIME_W-1:0] dur_c = (brake_duration > `DUR_MAX) ? `DUR_MAX : brake_duration;
  wire [`TIME_W-1:0] sdur_c = (start_brake_duration > `DUR_MAX) ? `DUR_MAX : start_brake_duration;
  wire [`CARR_W-1:0] carr_lo = (brake_carrier_freq < `CARR_MIN) ? `CARR_MIN : brake_carrier_freq;
  wire [`CARR_W-1:0] carr_c = (carr_lo > `CARR_MAX) ? `CARR_MAX : carr_lo;

  wire term_run = forward_run_input | reverse_run_input;
  wire any_run = term_run | keypad_run;
  wire below = (output_freq < thresh);
  wire ref_below = (freq_reference < thresh);

  // ************************************************************
  // Tick generator
  // ************************************************************
  // A timer loaded mid-period sees its first tick early, so it ends after N-1 to N periods.
  reg [`TICK_W-1:0] tick_cnt;
  reg tick;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= {`TICK_W{1'b0}};
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[`TICK_W-1:0] - 1'b1) begin
      tick_cnt <= {`TICK_W{1'b0}};
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_RUN = 7'h02;
  localparam [6:0] S_WAIT = 7'h04;
  localparam [6:0] S_STOPBR = 7'h08;
  localparam [6:0] S_STARTBR = 7'h10;
  localparam [6:0] S_EXTBR = 7'h20;
  localparam [6:0] S_FQBR = 7'h40;

  reg [6:0] state;
  reg [6:0] next_state;
  reg [`TIME_W-1:0] tcount;
  reg [`TIME_W-1:0] next_tcount;
  reg ext_prev;
  reg ext_latch;
  reg ext_keypad;
  reg next_ext_latch;
  reg next_ext_keypad;
  reg run_prev;

  wire ext_rise = ext_brake_input & ~ext_prev;
  // Edge mode latches a rising edge, so a short pulse starts a whole timed braking.
  // edge or level trigger
  wire ext_req = (brake_trigger_method == `TRIG_LEVEL) ? ext_brake_input : (ext_latch | ext_rise);
  wire run_rise = any_run & ~run_prev;
  wire tdone = (tcount == {`TIME_W{1'b0}});

  always @* begin
    next_state = state;
    next_tcount = (tick && !tdone) ? tcount - 1'b1 : tcount;
    next_ext_latch = ext_latch;
    next_ext_keypad = ext_keypad;
    if (ext_rise) begin
      next_ext_latch = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (mode_freq && forward_run_input && ref_below) begin
          next_state = S_FQBR;
        end else if (run_rise && mode_stop && sdur_c != {`TIME_W{1'b0}}) begin
          next_state = S_STARTBR;
          next_tcount = sdur_c;
        end else if (any_run) begin
          next_state = S_RUN;
        end
      end
      S_STARTBR: begin
        if (tdone) begin
          next_state = any_run ? S_RUN : S_IDLE;
        end
      end
      S_RUN: begin
        if (mode_freq) begin
          // no brake once forward run released
          if (forward_run_input && (below || ref_below)) begin
            next_state = S_FQBR;
          end else if (!any_run) begin
            next_state = S_IDLE;
          end
        end else if (ext_req) begin
          next_state = keypad_run ? S_WAIT : S_EXTBR;
          next_ext_keypad = keypad_run;
          next_tcount = wait_t;
        end else if (!any_run && mode_stop && below) begin
          next_ext_keypad = 1'b0;
          if (wait_c == {`TIME_W{1'b0}}) begin
            next_state = S_STOPBR;
            next_tcount = dur_c;
          end else begin
            next_state = S_WAIT;
            next_tcount = wait_c;
          end
        end else if (!any_run && !below) begin
          next_state = S_RUN;
        end else if (!any_run) begin
          next_state = S_IDLE;
        end
      end
      S_WAIT: begin
        if (mode_freq) begin
          next_state = any_run ? S_RUN : S_IDLE;
          next_ext_latch = 1'b0;
        end else if (tdone) begin
          next_state = ext_keypad ? S_EXTBR : S_STOPBR;
          next_tcount = dur_c;
        end
      end
      S_STOPBR: begin
        if (mode_freq) begin
          next_state = any_run ? S_RUN : S_IDLE;
        end else if (tdone) begin
          next_state = any_run ? S_RUN : S_IDLE;
        end
      end
      S_EXTBR: begin
        // frequency mode ignores the brake terminal
        if (mode_freq) begin
          next_state = any_run ? S_RUN : S_IDLE;
          next_ext_latch = 1'b0;
        end else if (!ext_req) begin
          next_state = (term_run && !ext_keypad) ? S_RUN : S_IDLE;
          next_ext_latch = 1'b0;
        // A new edge in the clearing cycle keeps the request latched.
        end else if (brake_trigger_method == `TRIG_EDGE && tdone && ext_latch && !ext_rise) begin
          next_ext_latch = 1'b0;
        end
      end
      S_FQBR: begin
        if (!mode_freq || !forward_run_input || (!ref_below && !below)) begin
          next_state = any_run ? S_RUN : S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (!ext_brake_input && brake_trigger_method == `TRIG_LEVEL) begin
      next_ext_latch = 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      tcount <= {`TIME_W{1'b0}};
      ext_prev <= 1'b0;
      ext_latch <= 1'b0;
      ext_keypad <= 1'b0;
      run_prev <= 1'b0;
    end else begin
      state <= next_state;
      tcount <= next_tcount;
      ext_prev <= ext_brake_input;
      ext_latch <= next_ext_latch;
      ext_keypad <= next_ext_keypad;
      run_prev <= any_run;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every braking state shares one flag, so the force and the flag switch together.
  wire next_braking = (next_state == S_STOPBR) || (next_state == S_STARTBR) ||
                      (next_state == S_EXTBR) || (next_state == S_FQBR);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brake_active <= 1'b0;
      coast <= 1'b0;
      resume_ramp <= 1'b0;
      keypad_stop <= 1'b0;
      brake_force <= {`LEVEL_W{1'b0}};
      carrier_freq <= `DEF_CARR;
    end else begin
      brake_active <= next_braking;
      coast <= (next_state == S_WAIT);
      resume_ramp <= (state == S_EXTBR) && (next_state == S_RUN) && !mode_freq;
      keypad_stop <= (state == S_EXTBR) && (next_state == S_IDLE) && ext_keypad && !mode_freq;
      if (!next_braking) begin
        brake_force <= {`LEVEL_W{1'b0}};
      end else if (next_state == S_STARTBR) begin
        brake_force <= slvl_c;
      end else begin
        brake_force <= lvl_c;
      end
      carrier_freq <= carr_c;
    end
  end

endmodule // dc_injection_brake_control

// [bench/dc_brake_props.sv]
// Concurrent checks on the DC brake sequencer ports.
`timescale 1ns/1ps
module dc_brake_props (
  // Clock and reset
  input logic clk_sys,
  input logic rst_n,
  // Settings and commands
  input logic [1:0] brake_mode_select,
  input logic [15:0] brake_threshold_freq,
  input logic [6:0] brake_level,
  input logic [7:0] brake_carrier_freq,
  input logic forward_run_input,
  input logic reverse_run_input,
  input logic keypad_run,
  input logic ext_brake_input,
  input logic [15:0] freq_reference,
  input logic [15:0] output_freq,
  // Power stage requests
  input logic brake_active,
  input logic coast,
  input logic resume_ramp,
  input logic keypad_stop,
  input logic [6:0] brake_force,
  input logic [7:0] carrier_freq
);
  wire run_any = forward_run_input | reverse_run_input | keypad_run;
  wire [7:0] carr_c = brake_carrier_freq < 8'h14 ? 8'h14 : (brake_carrier_freq > 8'h96 ? 8'h96 : brake_carrier_freq);
  wire [6:0] lvl_c = brake_level > 7'h64 ? 7'h64 : brake_level;
  wire below = freq_reference < brake_threshold_freq && output_freq < brake_threshold_freq;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_carrier_clamp: assert property ($past(rst_n) |-> carrier_freq == $past(carr_c))
    else $error("carrier frequency not clamped");
  a_stop_level: assert property ($rose(brake_active) && !$past(run_any) && brake_mode_select == 2'h1 |-> brake_force == lvl_c)
    else $error("stop brake force wrong");
  a_coast_excl: assert property (!(coast && brake_active))
    else $error("coast and brake together");
  a_coast_then_brake: assert property ($fell(coast) && $past(brake_mode_select) != 2'h2 |-> brake_active)
    else $error("coast not followed by brake");
  a_freq_no_run: assert property ((brake_mode_select == 2'h2 && !run_any) [*2] |=> !brake_active)
    else $error("brake without run in frequency mode");
  a_freq_brake: assert property ((brake_mode_select == 2'h2 && forward_run_input && below) [*2] |=> brake_active)
    else $error("no brake below threshold");
  a_resume_cause: assert property (resume_ramp |-> $past(ext_brake_input, 2) && !$past(ext_brake_input) && $past(forward_run_input))
    else $error("resume without brake release");
  a_kpd_stop: assert property (keypad_stop |-> $past(keypad_run) && !$past(ext_brake_input) ##1 !keypad_stop)
    else $error("keypad stop pulse wrong");
endmodule // dc_brake_props
bind dc_injection_brake_control dc_brake_props u_props (.*);

// [bench/motor_stage_model.sv]
// Behavioural motor: output frequency ramps toward the reference while running and not coasting, else toward zero.
`timescale 1ns/1ps
module motor_stage_model (
  // Clock and reset
  input logic clk_sys,
  input logic rst_n,
  // Drive state
  input logic run,
  input logic coast,
  input logic [15:0] fref,
  // Shaft frequency
  output logic [15:0] output_freq
);
  wire [15:0] target = (run && !coast) ? fref : 16'h0000;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) output_freq <= 16'h0000;
    else if (output_freq + 16'h0008 <= target) output_freq <= output_freq + 16'h0008;
    else if (output_freq >= target + 16'h0008) output_freq <= output_freq - 16'h0008;
    else output_freq <= target;
  end
endmodule // motor_stage_model

// [bench/dc_injection_brake_control_tb_top.sv]
// Self-checking bench for the DC injection brake sequencer.
`timescale 1ns/1ps
module dc_injection_brake_control_tb_top;
  logic clk_sys = 0, rst_n = 0, trig = 1, fwd = 0, kpd = 0, ext = 0;
  logic [1:0] mode = 2'h1;
  logic [15:0] thr = 16'h0032, fref = 16'h0000, out_f;
  logic [9:0] wt = 10'h000, dur = 10'h005, sdur = 10'h000;
  logic [6:0] lvl = 7'h32, slvl = 7'h00, lc;
  logic [7:0] carr = 8'h32;
  logic [16:0] cur = 0, exp_q[$];
  wire brk, cst, res, kst;
  wire [6:0] force_o;
  wire [7:0] carr_o;
  int err_total = 0, comparisons = 0, cyc = 0, len = 0, n_res = 0, n_kst = 0, seed = 32'h6ec9;
  initial forever #2 clk_sys = ~clk_sys;
  dc_injection_brake_control #(.TICK_CYCLES(10)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .brake_mode_select(mode), .brake_threshold_freq(thr), .start_freq(16'h0000), .brake_wait_time(wt),
    .brake_level(lvl), .brake_duration(dur), .brake_trigger_method(trig), .start_brake_level(slvl),
    .start_brake_duration(sdur), .brake_carrier_freq(carr), .forward_run_input(fwd),
    .reverse_run_input(1'b0), .keypad_run(kpd), .ext_brake_input(ext), .freq_reference(fref),
    .output_freq(out_f), .brake_active(brk), .coast(cst), .resume_ramp(res), .keypad_stop(kst),
    .brake_force(force_o), .carrier_freq(carr_o));
  motor_stage_model u_motor (.clk_sys(clk_sys), .rst_n(rst_n), .run(fwd | kpd), .coast(cst),
    .fref(fref), .output_freq(out_f));
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic settle();
    tick(150);
    for (int k = 0; k < 2000 && (brk | cst) !== 1'b0; k++) tick(1);
    if ((brk | cst) !== 1'b0) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic note(input logic [9:0] d);
    lc = lvl > 7'h64 ? 7'h64 : lvl;
    exp_q.push_back({lc, d});
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each brake start takes the oldest note; its length is checked on release when the note's duration is nonzero.
  always @(negedge clk_sys) begin
    n_res += res;
    n_kst += kst;
    if (brk === 1'b1) begin
      if (len == 0 && exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else if (len == 0) begin
        cur = exp_q.pop_front();
        chk(force_o, cur[16:10]);
      end
      len++;
    end else begin
      if (len > 0 && cur[9:0] != 0) chk(len > (cur[9:0] - 1) * 10 && len <= cur[9:0] * 10 + 1, 1);
      len = 0;
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tick(10);
    rst_n = 1;
    for (int i = 0; i < 4; i++) begin
      lvl = $random(seed);
      dur = 1 + {$random(seed)} % 10;
      wt = i;
      thr = 50 + {$random(seed)} % 550;
      carr = $random(seed);
      slvl = $random(seed);
      sdur = (i == 3) ? 10'h003 : 10'h000;
      fref = 1000;
      if (i == 3) exp_q.push_back({(slvl > 7'h64 ? 7'h64 : slvl), sdur});
      fwd = 1;
      tick(200);
      note(dur);
      fwd = 0;
      settle();
    end
    sdur = 10'h000;
    mode = 2'h0;
    fwd = 1;
    tick(200);
    fwd = 0;
    settle();
    mode = 2'h1;
    fwd = 1;
    tick(200);
    note(10'h000);
    ext = 1;
    tick(100);
    ext = 0;
    tick(5);
    chk(n_res, 1);
    mode = 2'h2;
    note(10'h000);
    fref = 0;
    tick(300);
    chk(brk, 1);
    fref = 1000;
    tick(300);
    chk(brk, 0);
    fwd = 0;
    fref = 0;
    ext = 1;
    tick(300);
    ext = 0;
    note(10'h000);
    fwd = 1;
    tick(50);
    chk(brk, 1);
    fref = 1000;
    tick(300);
    mode = 2'h0;
    fwd = 0;
    tick(300);
    kpd = 1;
    trig = 0;
    wt = 2;
    tick(2);
    mode = 2'h1;
    tick(200);
    note(10'h000);
    ext = 1;
    tick(5);
    ext = 0;
    tick(150);
    chk(n_kst, 1);
    mode = 2'h0;
    kpd = 0;
    tick(50);
    chk(exp_q.size(), 0);
    end_sim();
  end
endmodule // dc_injection_brake_control_tb_top
